// ---- verilog/dcp_pkg.sv ----
// shared types and constants for the ddr2 command pin interface
package dcp_pkg;

  // ==========================================================================
  // pin and bus widths
  localparam int DCP_BA_W   = 3;
  localparam int DCP_ADDR_W = 14;
  localparam int DCP_DQ_W   = 16;
  localparam int DCP_DM_W   = 2;
  localparam int DCP_BANKS  = 8;
  localparam int DCP_MR_N   = 4;

  // ==========================================================================
  // field positions
  localparam int DCP_AP_BIT  = 10;
  localparam int DCP_A11_BIT = 11;
  localparam int DCP_A13_BIT = 13;
  localparam int DCP_COL_W   = 10;

  // ==========================================================================
  // data organisation codes
  localparam logic [1:0] DCP_ORG_X4  = 2'h0;
  localparam logic [1:0] DCP_ORG_X8  = 2'h1;
  localparam logic [1:0] DCP_ORG_X16 = 2'h2;

  // ==========================================================================
  // ras/cas/we patterns with chip select low
  localparam logic [2:0] DCP_RCW_MRS = 3'h0;
  localparam logic [2:0] DCP_RCW_REF = 3'h1;
  localparam logic [2:0] DCP_RCW_PRE = 3'h2;
  localparam logic [2:0] DCP_RCW_ACT = 3'h3;
  localparam logic [2:0] DCP_RCW_WR  = 3'h4;
  localparam logic [2:0] DCP_RCW_RD  = 3'h5;

  // ==========================================================================
  // counts and reset values
  localparam logic [2:0]  DCP_BURST_BEATS = 3'h4;
  localparam int          DCP_FIFO_DEPTH  = 16;
  localparam logic [13:0] DCP_MR_RST      = 14'h0000;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    DCP_OP_NOP, DCP_OP_ACT, DCP_OP_RD, DCP_OP_WR,
    DCP_OP_PRE, DCP_OP_REF, DCP_OP_MRS
  } dcp_op_t;

  typedef enum logic [2:0] {
    DCP_ST_ACTIVE, DCP_ST_PPD, DCP_ST_APD, DCP_ST_SREF, DCP_ST_SREF_EXIT
  } dcp_pwr_t;

  typedef struct packed {
    logic                  ck;
    logic                  cke;
    logic                  cs_n;
    logic                  ras_n;
    logic                  cas_n;
    logic                  we_n;
    logic [DCP_BA_W-1:0]   ba;
    logic [DCP_ADDR_W-1:0] addr;
    logic [DCP_DM_W-1:0]   dm;
    logic                  dqs;
    logic [DCP_DQ_W-1:0]   dq;
  } dcp_pins_t;

  typedef struct packed {
    dcp_op_t               op;
    logic [DCP_BA_W-1:0]   ba;
    logic [DCP_ADDR_W-1:0] addr;
    logic                  ap;
    logic                  all_banks;
  } dcp_cmd_t;

  typedef struct packed {
    logic [DCP_DQ_W-1:0] data;
    logic [DCP_DM_W-1:0] be;
  } dcp_beat_t;

  typedef logic [DCP_MR_N-1:0][DCP_ADDR_W-1:0] dcp_mr_file_t;

endpackage

// ---- verilog/dcp_top.sv ----
// write-data fifo and device-side command pin logic of the ddr2 interface
`timescale 1ns/100ps
`default_nettype none

// ============================================================================
// fifo
module dcp_fifo #(
  parameter int W     = 18,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         clk_en,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready && clk_en;
  assign pop       = out_valid && out_ready && clk_en;
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule // dcp_fifo

// ============================================================================
// device top
// Functional notes
// - sample commands on ck rising crossing
// - read data beats on both ck edges
// - cke low stops clocks, inputs, drivers
// - cke low: idle precharge/self-refresh, open active
// - cke registered on ck for power-down
// - self-refresh: only cke; async exit detect
// - power-down: only ck, odt, cke live
// - chip select high masks the command
// - command from cs, ras, cas, we
// - high data mask clears the write beat's byte enable
// - mask sampled on both strobe edges
// - x16 has lower and upper masks
// - x8 mask disabled when rdqs enabled
// - three bank bits pick eight banks
// - ba0/ba1 pick mode register at mrs
// - row on activate, column plus a10
// - precharge a10 low one, high all
// - mrs loads address as op-code
// - a13 row bit unused on x16
// - data bus 4, 8 or 16 wide
module dcp_top
  import dcp_pkg::*;
(
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       resetn,
  input  wire logic                       clk_en,
  // memory pins from the controller
  input  wire dcp_pkg::dcp_pins_t         pins_i,
  output logic [dcp_pkg::DCP_DQ_W-1:0]    dq_o,
  output logic                            dq_oe,
  // configuration
  input  wire logic [1:0]                 org,
  input  wire logic                       rdqs_en,
  // command report
  output logic                            cmd_valid,
  output dcp_pkg::dcp_cmd_t               cmd,
  output dcp_pkg::dcp_pwr_t               pwr_state,
  output logic [dcp_pkg::DCP_BANKS-1:0]   bank_open,
  output dcp_pkg::dcp_mr_file_t           mode_regs,
  // read data source
  output logic                            rd_beat,
  input  wire logic [dcp_pkg::DCP_DQ_W-1:0] rd_data,
  // write data sink
  output logic                            wr_valid,
  input  wire logic                       wr_ready,
  output dcp_pkg::dcp_beat_t              wr_beat,
  output logic                            wr_overrun
);
  import dcp_pkg::*;

  // ==========================================================================
  // pin synchroniser
  dcp_pins_t s1_q, s2_q, s3_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (clk_en) begin
      s1_q <= pins_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  logic ck_rise, ck_fall, dqs_edge;
  assign ck_rise  = clk_en && s2_q.ck && !s3_q.ck;
  assign ck_fall  = clk_en && !s2_q.ck && s3_q.ck;
  assign dqs_edge = clk_en && (s2_q.dqs != s3_q.dqs);

  // ==========================================================================
  // command decode
  dcp_pwr_t  st_q;
  dcp_op_t   op;
  logic      run;
  logic [DCP_BANKS-1:0] open_q;

  // commands only count when awake and cke registered high
  assign run = ck_rise && (st_q == DCP_ST_ACTIVE) && s2_q.cke;

  always_comb begin
    op = DCP_OP_NOP;
    if (!s2_q.cs_n) begin
      case ({s2_q.ras_n, s2_q.cas_n, s2_q.we_n})
        DCP_RCW_MRS: op = DCP_OP_MRS;
        DCP_RCW_REF: op = DCP_OP_REF;
        DCP_RCW_PRE: op = DCP_OP_PRE;
        DCP_RCW_ACT: op = DCP_OP_ACT;
        DCP_RCW_WR:  op = DCP_OP_WR;
        DCP_RCW_RD:  op = DCP_OP_RD;
        default:     op = DCP_OP_NOP;
      endcase
    end
  end

  // row address loses a13 on x16; column keeps a11 only on x4
  logic [DCP_ADDR_W-1:0] row_addr, col_addr;
  always_comb begin
    row_addr = s2_q.addr;
    if (org == DCP_ORG_X16) begin
      row_addr[DCP_A13_BIT] = 1'b0;
    end
    col_addr = {{(DCP_ADDR_W-DCP_COL_W){1'b0}}, s2_q.addr[DCP_COL_W-1:0]};
    if (org == DCP_ORG_X4) begin
      col_addr[DCP_A11_BIT] = s2_q.addr[DCP_A11_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cmd_valid <= 1'b0;
      cmd       <= '0;
    end else if (clk_en) begin
      cmd_valid <= run && (op != DCP_OP_NOP);
      if (run && (op != DCP_OP_NOP)) begin
        cmd.op        <= op;
        cmd.ba        <= s2_q.ba;
        cmd.addr      <= (op == DCP_OP_ACT) ? row_addr :
                         (op == DCP_OP_MRS) ? s2_q.addr : col_addr;
        cmd.ap        <= s2_q.addr[DCP_AP_BIT];
        cmd.all_banks <= (op == DCP_OP_PRE) && s2_q.addr[DCP_AP_BIT];
      end
    end
  end

  // ==========================================================================
  // bank state, one slice per bank
  logic [DCP_BANKS-1:0][DCP_ADDR_W-1:0] row_q;

  genvar b;
  generate
    for (b = 0; b < DCP_BANKS; b++) begin : g_bank
      logic hit;
      assign hit = (s2_q.ba == DCP_BA_W'(b));
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          open_q[b] <= 1'b0;
          row_q[b]  <= '0;
        end else if (run) begin
          if (op == DCP_OP_ACT && hit) begin
            open_q[b] <= 1'b1;
            row_q[b]  <= row_addr;
          end else if (op == DCP_OP_PRE && (hit || s2_q.addr[DCP_AP_BIT])) begin
            open_q[b] <= 1'b0;
          end else if ((op == DCP_OP_RD || op == DCP_OP_WR) && hit
                       && s2_q.addr[DCP_AP_BIT]) begin
            open_q[b] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign bank_open = open_q;

  // ==========================================================================
  // mode registers
  dcp_mr_file_t mr_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mr_q <= {DCP_MR_N{DCP_MR_RST}};
    end else if (run && op == DCP_OP_MRS) begin
      mr_q[s2_q.ba[1:0]] <= s2_q.addr;
    end
  end

  assign mode_regs = mr_q;

  // ==========================================================================
  // power states
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q <= DCP_ST_ACTIVE;
    end else if (clk_en) begin
      case (st_q)
        DCP_ST_ACTIVE: begin
          if (ck_rise && !s2_q.cke) begin
            if (op == DCP_OP_REF && open_q == '0) begin
              st_q <= DCP_ST_SREF;
            end else if (open_q != '0) begin
              st_q <= DCP_ST_APD;
            end else begin
              st_q <= DCP_ST_PPD;
            end
          end
        end
        DCP_ST_PPD, DCP_ST_APD: begin
          if (ck_rise && s2_q.cke) begin
            st_q <= DCP_ST_ACTIVE;
          end
        end
        // exit seen from cke alone, ck may be stopped here
        DCP_ST_SREF: begin
          if (s2_q.cke) begin
            st_q <= DCP_ST_SREF_EXIT;
          end
        end
        DCP_ST_SREF_EXIT: begin
          if (!s2_q.cke) begin
            st_q <= DCP_ST_SREF;
          end else if (ck_rise) begin
            st_q <= DCP_ST_ACTIVE;
          end
        end
        default: st_q <= DCP_ST_ACTIVE;
      endcase
    end
  end

  assign pwr_state = st_q;

  // ==========================================================================
  // read burst, one beat on every ck edge
  logic [2:0] rd_left_q;
  logic       awake;
  logic [DCP_DQ_W-1:0] width_mask;

  // drivers and strobes only live while awake with cke high
  assign awake = (st_q == DCP_ST_ACTIVE) && s2_q.cke;
  assign width_mask = (org == DCP_ORG_X4) ? 16'h000f :
                      (org == DCP_ORG_X8) ? 16'h00ff : 16'hffff;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_left_q <= '0;
      dq_o      <= '0;
      dq_oe     <= 1'b0;
      rd_beat   <= 1'b0;
    end else if (clk_en) begin
      rd_beat <= 1'b0;
      if (!awake) begin
        rd_left_q <= '0;
        dq_oe     <= 1'b0;
      end else if (run && op == DCP_OP_RD) begin
        rd_left_q <= DCP_BURST_BEATS;
      end else if ((ck_rise || ck_fall) && rd_left_q != '0) begin
        rd_left_q <= rd_left_q - 3'h1;
        dq_o      <= rd_data & width_mask;
        dq_oe     <= 1'b1;
        rd_beat   <= 1'b1;
      end else if ((ck_rise || ck_fall) && rd_left_q == '0) begin
        dq_oe <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // write burst, one beat on every strobe edge
  logic [2:0] wr_left_q;
  logic       wr_take;
  logic       fifo_ready;
  dcp_beat_t  beat_d;

  assign wr_take = dqs_edge && awake && (wr_left_q != '0);

  always_comb begin
    beat_d.data = s2_q.dq & width_mask;
    beat_d.be   = 2'h3;
    if (org == DCP_ORG_X16) begin
      beat_d.be = ~s2_q.dm;
    end else if (!(org == DCP_ORG_X8 && rdqs_en)) begin
      beat_d.be = {1'b1, ~s2_q.dm[0]};
    end
    if (org != DCP_ORG_X16) begin
      beat_d.be[1] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_left_q  <= '0;
      wr_overrun <= 1'b0;
    end else if (clk_en) begin
      if (!awake) begin
        wr_left_q <= '0;
      end else if (run && op == DCP_OP_WR) begin
        wr_left_q <= DCP_BURST_BEATS;
      end else if (wr_take) begin
        wr_left_q <= wr_left_q - 3'h1;
      end
      // beats arriving into a full fifo are lost and flagged
      if (wr_take && !fifo_ready) begin
        wr_overrun <= 1'b1;
      end
    end
  end

  dcp_fifo #(
    .W     ($bits(dcp_beat_t)),
    .DEPTH (DCP_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .clk_en    (clk_en),
    .in_valid  (wr_take),
    .in_ready  (fifo_ready),
    .in_data   (beat_d),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (wr_beat)
  );

  // ==========================================================================
  // checks
  a_cs_masks: assert property (@(posedge clk_sys) disable iff (!resetn)
    ck_rise && s2_q.cs_n |=> !cmd_valid) else $error("deselected command taken");

  a_act_decode: assert property (@(posedge clk_sys) disable iff (!resetn)
    run && !s2_q.cs_n && {s2_q.ras_n, s2_q.cas_n, s2_q.we_n} == DCP_RCW_ACT
    |=> cmd_valid && cmd.op == DCP_OP_ACT) else $error("activate not decoded");

  a_act_opens: assert property (@(posedge clk_sys) disable iff (!resetn)
    run && op == DCP_OP_ACT |=> open_q[$past(s2_q.ba)]) else $error("bank not opened");

  a_pre_all: assert property (@(posedge clk_sys) disable iff (!resetn)
    run && op == DCP_OP_PRE && s2_q.addr[DCP_AP_BIT] |=> open_q == '0)
    else $error("precharge all left a bank open");

  a_pd_entry: assert property (@(posedge clk_sys) disable iff (!resetn)
    ck_rise && st_q == DCP_ST_ACTIVE && !s2_q.cke && op != DCP_OP_REF
    |=> st_q == (($past(open_q) == '0) ? DCP_ST_PPD : DCP_ST_APD))
    else $error("wrong power-down kind");

  a_sref_exit: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && st_q == DCP_ST_SREF && s2_q.cke |=> st_q == DCP_ST_SREF_EXIT)
    else $error("self-refresh exit missed");

  a_oe_asleep: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && !awake |=> !dq_oe) else $error("driver on while asleep");

  a_mrs_load: assert property (@(posedge clk_sys) disable iff (!resetn)
    run && op == DCP_OP_MRS |=> mr_q[$past(s2_q.ba[1:0])] == $past(s2_q.addr))
    else $error("mode register not loaded");

  a_mask_low: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_take && s2_q.dm[0] && !(org == DCP_ORG_X8 && rdqs_en) |-> !beat_d.be[0])
    else $error("masked byte enabled");

  a_row_a13: assert property (@(posedge clk_sys) disable iff (!resetn)
    run && op == DCP_OP_ACT && org == DCP_ORG_X16
    |=> !row_q[$past(s2_q.ba)][DCP_A13_BIT]) else $error("a13 used on x16");

  a_read_beats: assert property (@(posedge clk_sys) disable iff (!resetn)
    awake && ck_fall && rd_left_q != '0 && !run |=> rd_beat && dq_oe)
    else $error("no beat on falling edge");

endmodule // dcp_top

`default_nettype wire

// ---- test/dcp_ctrl_model.sv ----
// controller-side pin driver for the ddr2 command pin bench
`timescale 1ns/100ps
`default_nettype none

// ================
// controller model
module dcp_ctrl_model (
  // clock
  input  wire logic              clk_sys,
  // memory pins
  output var dcp_pkg::dcp_pins_t pins
);
  import dcp_pkg::*;
  dcp_pins_t cur;

  initial begin
    cur = '0;
    cur.cke = 1'b1;
    {cur.cs_n, cur.ras_n, cur.cas_n, cur.we_n} = 4'hf;
    pins = cur;
  end

  // one ck half is four system clocks, so pins hold past the sync depth
  task automatic step();
    @(posedge clk_sys);
    pins <= cur;
    repeat (3) @(posedge clk_sys);
  endtask

  // command set up in the low half, captured at the rise
  task automatic cyc(input logic ke, input logic cs, input logic [2:0] rcw,
                     input logic [2:0] ba, input logic [13:0] a);
    cur.ck = 1'b0;
    cur.cke = ke;
    cur.cs_n = cs;
    {cur.ras_n, cur.cas_n, cur.we_n} = rcw;
    cur.ba = ba;
    cur.addr = a;
    step();
    cur.ck = 1'b1;
    step();
    {cur.cs_n, cur.ras_n, cur.cas_n, cur.we_n} = 4'hf;
  endtask

  // four beats on the next ck halves; cke is never touched here
  task automatic beats(input logic [63:0] d, input logic [7:0] m, input logic wr);
    for (int i = 0; i < 4; i++) begin
      cur.ck = ~cur.ck;
      cur.dqs = cur.dqs ^ wr;
      if (wr) cur.dq = d[16*i +: 16];
      cur.dm = m[2*i +: 2];
      step();
    end
    // released bus shows the inverse, never a stale copy
    cur.dq = ~cur.dq;
  endtask

  // cke change with ck standing still
  task automatic set_cke(input logic v);
    cur.cke = v;
    step();
  endtask
endmodule // dcp_ctrl_model

`default_nettype wire

// ---- test/test_ddr2_command_pin_interface.sv ----
// self-checking bench for the ddr2 command pin interface
`timescale 1ns/100ps
`default_nettype none

// ==========
// bench top
module test_ddr2_command_pin_interface;
  import dcp_pkg::*;

  typedef struct packed {
    dcp_op_t     op;
    logic [2:0]  ba;
    logic [13:0] addr;
    logic [13:0] amask;
  } dcp_note_t;

  logic         clk_sys, resetn, rdqs_en, wr_ready, stall, last_ck, clk_en;
  logic [1:0]   org;
  logic [15:0]  rd_data, dq_o;
  logic         dq_oe, cmd_valid, rd_beat, wr_valid, wr_overrun;
  logic [7:0]   bank_open;
  dcp_pins_t    pins;
  dcp_cmd_t     cmd;
  dcp_pwr_t     pwr_state;
  dcp_mr_file_t mode_regs;
  dcp_beat_t    wr_beat;
  dcp_note_t    cmd_q[$];
  logic [15:0]  rd_q[$];
  dcp_beat_t    wr_q[$];
  logic [13:0]  mr_v[4];
  int           fail_count, cmp_count, rd_left;

  dcp_ctrl_model ctrl_u (.clk_sys(clk_sys), .pins(pins));

  dcp_top dut_u (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .pins_i(pins),
    .dq_o(dq_o), .dq_oe(dq_oe), .org(org), .rdqs_en(rdqs_en), .cmd_valid(cmd_valid),
    .cmd(cmd), .pwr_state(pwr_state), .bank_open(bank_open), .mode_regs(mode_regs),
    .rd_beat(rd_beat), .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_beat(wr_beat), .wr_overrun(wr_overrun));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ==========
  // helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  function automatic logic [15:0] wmask();
    return org == DCP_ORG_X4 ? 16'h000f : org == DCP_ORG_X8 ? 16'h00ff : 16'hffff;
  endfunction

  function automatic logic [1:0] be_of(input logic [1:0] m);
    if (org == DCP_ORG_X16) return ~m;
    if (org == DCP_ORG_X8 && rdqs_en) return 2'h1;
    return {1'b0, ~m[0]};
  endfunction

  task automatic issue(input dcp_op_t op, input logic [2:0] rcw, input logic [2:0] ba,
                       input logic [13:0] a, input logic [13:0] am);
    cmd_q.push_back(dcp_note_t'{op, ba, a, am});
    ctrl_u.cyc(1'b1, 1'b0, rcw, ba, a);
  endtask

  // lost beats of an overrun are not noted
  task automatic wburst(input logic keep);
    logic [63:0] d;
    logic [7:0]  m;
    d = {$urandom, $urandom};
    m = 8'($urandom);
    for (int i = 0; i < 4; i++)
      if (keep) wr_q.push_back(dcp_beat_t'{d[16*i +: 16] & wmask(), be_of(m[2*i +: 2])});
    ctrl_u.beats(d, m, 1'b1);
  endtask

  task automatic cfg(input logic [1:0] o, input logic r);
    @(posedge clk_sys);
    org <= o;
    rdqs_en <= r;
  endtask

  task automatic power(input dcp_pwr_t s);
    repeat (3) @(negedge clk_sys);
    chk("pwr_state", 32'(s), 32'(pwr_state));
  endtask

  task automatic drain();
    for (int n = 0; n < 400 && cmd_q.size() + rd_q.size() + wr_q.size() > 0; n++)
      @(posedge clk_sys);
    if (cmd_q.size() + rd_q.size() + wr_q.size() > 0) begin
      chk("queues_empty", 32'h1, 32'h0);
      conclude();
    end
    @(negedge clk_sys);
  endtask

  // ==========
  // stimulus side of the data paths
  always @(posedge clk_sys) wr_ready <= stall ? 1'b0 : 1'($urandom);

  // read data changes on every ck half; beats after a read edge are noted
  always @(posedge clk_sys) begin
    logic [15:0] v;
    last_ck <= pins.ck;
    if (pins.ck !== last_ck) begin
      v = 16'($urandom);
      rd_data <= v;
      if (rd_left > 0) begin
        rd_q.push_back(v & wmask());
        rd_left--;
      end
      if (pins.ck && !pins.cs_n && pins.cke && {pins.ras_n, pins.cas_n, pins.we_n} == DCP_RCW_RD)
        rd_left = 4;
    end
  end

  // ==========
  // result watcher
  always @(posedge clk_sys) begin
    dcp_note_t n;
    dcp_beat_t b;
    if (cmd_valid === 1'b1) begin
      if (cmd_q.size() == 0) chk("cmd_valid", 32'h0, 32'h1);
      else begin
        n = cmd_q.pop_front();
        chk("cmd.op", 32'(n.op), 32'(cmd.op));
        chk("cmd.ba", 32'(n.ba), 32'(cmd.ba));
        chk("cmd.addr", 32'(n.addr & n.amask), 32'(cmd.addr & n.amask));
        chk("cmd.all_banks", 32'(n.op == DCP_OP_PRE && n.addr[DCP_AP_BIT]),
            32'(cmd.all_banks));
        if (n.op == DCP_OP_RD || n.op == DCP_OP_WR)
          chk("cmd.ap", 32'(n.addr[DCP_AP_BIT]), 32'(cmd.ap));
      end
    end
    if (rd_beat === 1'b1) begin
      chk("dq_oe", 32'h1, 32'(dq_oe));
      if (rd_q.size() == 0) chk("rd_beat", 32'h0, 32'h1);
      else chk("dq_o", 32'(rd_q.pop_front()), 32'(dq_o));
    end
    if (wr_valid === 1'b1 && wr_ready === 1'b1 && clk_en === 1'b1) begin
      if (wr_q.size() == 0) chk("wr_valid", 32'h0, 32'h1);
      else begin
        b = wr_q.pop_front();
        chk("wr_beat", 32'(b), 32'(wr_beat));
      end
    end
  end

  // ==========
  // main sequence
  initial begin
    void'($urandom(82186));
    resetn = 1'b0;
    rdqs_en = 1'b0;
    stall = 1'b0;
    clk_en = 1'b1;
    last_ck = 1'b0;
    wr_ready = 1'b0;
    rd_data = 16'h0000;
    org = DCP_ORG_X16;
    fail_count = 0;
    cmp_count = 0;
    rd_left = 0;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    @(negedge clk_sys);
    chk("bank_open", 32'h0, 32'(bank_open));
    for (int i = 0; i < 4; i++) begin
      mr_v[i] = 14'($urandom);
      issue(DCP_OP_MRS, DCP_RCW_MRS, 3'(i), mr_v[i], 14'h3fff);
    end
    drain();
    for (int i = 0; i < 4; i++) chk("mode_regs", 32'(mr_v[i]), 32'(mode_regs[i]));
    for (int i = 0; i < 8; i++) issue(DCP_OP_ACT, DCP_RCW_ACT, 3'(i), 14'($urandom), 14'h1fff);
    ctrl_u.cyc(1'b1, 1'b1, DCP_RCW_PRE, 3'h0, 14'h0400);
    drain();
    chk("bank_open", 32'hff, 32'(bank_open));
    issue(DCP_OP_PRE, DCP_RCW_PRE, 3'h3, 14'h0000, 14'h0000);
    drain();
    chk("bank_open", 32'hf7, 32'(bank_open));
    issue(DCP_OP_PRE, DCP_RCW_PRE, 3'h5, 14'h0400, 14'h0000);
    drain();
    chk("bank_open", 32'h00, 32'(bank_open));
    ctrl_u.cyc(1'b0, 1'b1, 3'h7, 3'h0, 14'h0000);
    power(DCP_ST_PPD);
    ctrl_u.cyc(1'b0, 1'b0, DCP_RCW_ACT, 3'h1, 14'h0000);
    ctrl_u.cyc(1'b1, 1'b1, 3'h7, 3'h0, 14'h0000);
    power(DCP_ST_ACTIVE);
    issue(DCP_OP_ACT, DCP_RCW_ACT, 3'h6, 14'h0012, 14'h1fff);
    ctrl_u.cyc(1'b0, 1'b1, 3'h7, 3'h0, 14'h0000);
    power(DCP_ST_APD);
    ctrl_u.cyc(1'b1, 1'b1, 3'h7, 3'h0, 14'h0000);
    issue(DCP_OP_PRE, DCP_RCW_PRE, 3'h0, 14'h0400, 14'h0000);
    ctrl_u.cyc(1'b0, 1'b0, DCP_RCW_REF, 3'h0, 14'h0000);
    power(DCP_ST_SREF);
    // clock enable low must hold self-refresh although cke is back
    @(posedge clk_sys);
    clk_en <= 1'b0;
    ctrl_u.set_cke(1'b1);
    power(DCP_ST_SREF);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    repeat (3) @(posedge clk_sys);
    power(DCP_ST_SREF_EXIT);
    ctrl_u.cyc(1'b1, 1'b1, 3'h7, 3'h0, 14'h0000);
    power(DCP_ST_ACTIVE);
    for (int o = 0; o < 3; o++) begin
      cfg(2'(o), 1'b0);
      issue(DCP_OP_ACT, DCP_RCW_ACT, 3'h2, 14'h0100, 14'h1fff);
      issue(DCP_OP_RD, DCP_RCW_RD, 3'h2, 14'h0400, 14'h0000);
      ctrl_u.beats(64'h0, 8'h0, 1'b0);
      // the driver only turns off on the ck edge after the last beat
      ctrl_u.cyc(1'b1, 1'b1, 3'h7, 3'h0, 14'h0000);
      drain();
      chk("bank_open", 32'h0, 32'(bank_open));
      chk("dq_oe", 32'h0, 32'(dq_oe));
    end
    for (int c = 0; c < 4; c++) begin
      cfg(c == 0 ? DCP_ORG_X4 : c == 3 ? DCP_ORG_X16 : DCP_ORG_X8, c == 2);
      issue(DCP_OP_ACT, DCP_RCW_ACT, 3'h4, 14'h0020, 14'h1fff);
      issue(DCP_OP_WR, DCP_RCW_WR, 3'h4, 14'h0400, 14'h0000);
      wburst(1'b1);
      drain();
    end
    // far side stalls: sixteen words fill the buffer, the fifth burst is lost
    stall = 1'b1;
    issue(DCP_OP_ACT, DCP_RCW_ACT, 3'h0, 14'h0000, 14'h1fff);
    for (int i = 0; i < 5; i++) begin
      issue(DCP_OP_WR, DCP_RCW_WR, 3'h0, 14'h0008, 14'h0000);
      wburst(i < 4);
      if (i == 3) chk("wr_overrun", 32'h0, 32'(wr_overrun));
    end
    repeat (3) @(negedge clk_sys);
    chk("wr_overrun", 32'h1, 32'(wr_overrun));
    stall = 1'b0;
    drain();
    conclude();
  end
endmodule // test_ddr2_command_pin_interface

`default_nettype wire
